// File: design/rsq_reset_seq.v
`timescale 1ns/100ps
`include "rsq_defs.vh"
module rsq_reset_seq #(
   parameter REG_WAKE_CYC   = 16'd200,   // regulator start-up cycles
   parameter PLL_LOCK_CYC   = 16'd400,   // pll lock cycles
   parameter FRC_START_CYC  = 16'd20,    // fast rc start-up cycles
   parameter LOW_POWER_RC_OSCILLATOR_START_CYC = 16'd40,    // low power rc start-up cycles
   parameter DCO_START_CYC  = 16'd20,    // tunable osc start-up cycles
   parameter MON_DELAY_CYC  = 16'd8      // clock monitor start delay
) (
   sys_clk,
   reset_n,
   clk_en,
   por_event,
   brownout_low,
   brownout_enable_config,
   master_clear_pin,
   watchdog_timeout_reset,
   software_reset_instruction,
   illegal_opcode_reset,
   trap_conflict_reset,
   config_mismatch_reset,
   initial_oscillator_select,
   clock_switch_enable,
   two_speed_enable,
   clock_fail_monitor_enable,
   osc_tick,
   pll_locked,
   clock_valid,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   master_system_reset,
   exec_enable,
   clock_source,
   osc_fail_trap,
   monitor_active
);
   input         sys_clk;                     // block clock 200 mhz
   input         reset_n;                     // async reset, active low
   input         clk_en;                      // freeze all state but the reset release chain while low
   input         por_event;                   // power-on pulse
   input         brownout_low;                // supply under threshold
   input  [1:0]  brownout_enable_config;      // detector enable field
   input         master_clear_pin;            // pin reset, high active
   input         watchdog_timeout_reset;      // watchdog request
   input         software_reset_instruction;  // reset instruction
   input         illegal_opcode_reset;        // opcode or uninit w
   input         trap_conflict_reset;         // trap conflict
   input         config_mismatch_reset;       // config mismatch
   input  [2:0]  initial_oscillator_select;   // configured clock
   input         clock_switch_enable;         // switching allowed
   input         two_speed_enable;            // two-speed start-up
   input         clock_fail_monitor_enable;   // monitor enabled
   input         osc_tick;                    // one per crystal period
   input         pll_locked;                  // pll has lock
   input         clock_valid;                 // selected clock running
   input  [3:0]  reg_addr;                    // register index
   input  [15:0] reg_wdata;                   // write data
   input         reg_wr;                      // write strobe
   input         reg_rd;                      // read strobe
   output [15:0] reg_rdata;                   // read data, next cycle
   output        master_system_reset;         // high while in reset
   output        exec_enable;                 // cpu may run
   output [2:0]  clock_source;                // active system clock
   output        osc_fail_trap;               // oscillator failure trap
   output        monitor_active;              // monitor supervising

   wire          sys_clk;
   wire          reset_n;
   wire          clk_en;
   wire          por_event;
   wire          brownout_low;
   wire   [1:0]  brownout_enable_config;
   wire          master_clear_pin;
   wire          watchdog_timeout_reset;
   wire          software_reset_instruction;
   wire          illegal_opcode_reset;
   wire          trap_conflict_reset;
   wire          config_mismatch_reset;
   wire   [2:0]  initial_oscillator_select;
   wire          clock_switch_enable;
   wire          two_speed_enable;
   wire          clock_fail_monitor_enable;
   wire          osc_tick;
   wire          pll_locked;
   wire          clock_valid;
   wire   [3:0]  reg_addr;
   wire   [15:0] reg_wdata;
   wire          reg_wr;
   wire          reg_rd;

   // sequencer states
   localparam ST_IDLE = 2'h0;   // running
   localparam ST_HOLD = 2'h1;   // system reset delay
   localparam ST_CLK  = 2'h2;   // waiting for clock release
   localparam ST_MON  = 2'h3;   // one cycle, cpu enabled, then running

   reg    [1:0]  rst_sync_reg;                // reset release chain
   wire          rst_n;                       // synchronised reset
   reg    [1:0]  state_reg;                   // sequencer state
   reg    [1:0]  state_next;
   reg    [15:0] reset_cause_register;        // cause flags
   reg    [15:0] oscillator_control_register; // current select and fail
   reg    [15:0] flash_control_register;      // flash control
   reg    [15:0] rdata_reg;                   // read data
   reg           first_reg;                   // first sequence is power-on
   reg           two_speed_reg;               // on fast rc, primary pending
   reg    [2:0]  target_reg;                  // selected clock after reset
   reg           trap_reg;                    // oscillator fail trap
   reg           mon_reg;                     // monitor active
   wire   [15:0] req_vec;                     // request per flag
   wire          any_req;                     // any reset request
   wire          is_por;
   wire          is_bor;
   reg    [15:0] hold_len;                    // system reset delay
   reg    [15:0] clk_len;                     // clock start-up delay
   wire          hold_done;
   wire          clk_done;
   wire          xtal_done;
   wire   [2:0]  cur_sel;
   wire   [2:0]  post_sel;
   wire          need_xtal;
   wire          need_pll;
   wire          start;

   // ****************************************************************
   // reset release
   // ****************************************************************
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // ****************************************************************
   // request gathering; inputs are synchronous to sys_clk
   // ****************************************************************
   assign req_vec[`RSQ_F_POR]  = por_event;
   assign req_vec[`RSQ_F_BOR]  = por_event |
                                 (brownout_low & (brownout_enable_config != 2'b00));
   assign req_vec[`RSQ_F_WDT]  = watchdog_timeout_reset;
   assign req_vec[`RSQ_F_SWR]  = software_reset_instruction;
   assign req_vec[`RSQ_F_PIN]  = master_clear_pin;
   assign req_vec[`RSQ_F_CM]   = config_mismatch_reset;
   assign req_vec[`RSQ_F_IOP]  = illegal_opcode_reset;
   assign req_vec[`RSQ_F_TRAP] = trap_conflict_reset;
   assign req_vec[2]           = 1'b0;
   assign req_vec[3]           = 1'b0;
   assign req_vec[5]           = 1'b0;
   assign req_vec[8]           = 1'b0;
   assign req_vec[13:10]       = 4'h0;
   assign any_req = (|req_vec) | first_reg;
   assign is_por  = por_event | first_reg;
   assign is_bor  = req_vec[`RSQ_F_BOR] & ~is_por;
   assign start   = any_req;

   // ****************************************************************
   // clock selection after reset
   // ****************************************************************
   assign cur_sel  = oscillator_control_register[`RSQ_OSC_CUR_HI:`RSQ_OSC_CUR_LO];
   // power-on/brown-out or switching disabled take the config select
   assign post_sel = (!clock_switch_enable || is_por || is_bor) ?
                     initial_oscillator_select : cur_sel;
   assign need_xtal = (target_reg == `RSQ_OSC_PRI) || (target_reg == `RSQ_OSC_PRIPLL) ||
                      (target_reg == `RSQ_OSC_SOSC);
   assign need_pll  = (target_reg == `RSQ_OSC_PRIPLL) || (target_reg == `RSQ_OSC_FRCPLL);

   // ****************************************************************
   // delay lengths per cause and source
   // ****************************************************************
   always @* begin
      hold_len = `RSQ_RST_CYC;
      if (is_por) begin
         hold_len = `RSQ_POR_CYC + REG_WAKE_CYC + `RSQ_RST_CYC;
      end else if (is_bor) begin
         hold_len = REG_WAKE_CYC + `RSQ_RST_CYC;
         if (post_sel == `RSQ_OSC_DCO) begin
            hold_len = `RSQ_POR_CYC + REG_WAKE_CYC + `RSQ_RST_CYC;
         end
      end
   end

   // per-source wait, crystal part handled by the period counter
   always @* begin
      case (post_sel)
         `RSQ_OSC_FRC, `RSQ_OSC_FRCDIV: clk_len = FRC_START_CYC;
         `RSQ_OSC_FRCPLL:               clk_len = FRC_START_CYC + PLL_LOCK_CYC;
         `RSQ_OSC_PRIPLL:               clk_len = PLL_LOCK_CYC;
         `RSQ_OSC_LOW_POWER_RC_OSCILLATOR:                 clk_len = LOW_POWER_RC_OSCILLATOR_START_CYC;
         `RSQ_OSC_DCO:                  clk_len = DCO_START_CYC;
         default:                       clk_len = 16'h0000;
      endcase
      if (two_speed_enable && (post_sel == `RSQ_OSC_PRI || post_sel == `RSQ_OSC_PRIPLL)) begin
         clk_len = FRC_START_CYC;
      end
   end

   // ****************************************************************
   // timers, all loaded together so waits overlap
   // ****************************************************************
   rsq_delay_cnt u_hold (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .load     (start),
      .load_val (hold_len),
      .tick     (1'b1),
      .done     (hold_done)
   );
   rsq_delay_cnt u_clk (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .load     (start),
      .load_val (clk_len),
      .tick     (1'b1),
      .done     (clk_done)
   );
   // crystal periods: 1024 ticks, the 11th bit only holds the load
   rsq_delay_cnt u_xtal (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .load     (start),
      .load_val ({5'h00, `RSQ_XTAL_PERIODS}),
      .tick     (osc_tick),
      .done     (xtal_done)
   );

   // ****************************************************************
   // sequencer state machine
   // ****************************************************************
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: state_next = ST_IDLE;
         ST_HOLD: if (hold_done) state_next = ST_CLK;
         ST_CLK: begin
            // waits run beside the reset delay, so often already done
            if (clk_done && (!need_xtal || two_speed_reg || xtal_done) &&
                (!need_pll || two_speed_reg || pll_locked)) begin
               state_next = ST_MON;
            end
         end
         ST_MON: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
      if (start) begin
         state_next = ST_HOLD;
      end
   end

   // monitor delay counter
   wire mon_done;
   rsq_delay_cnt u_mon (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .load     (start | (state_reg == ST_HOLD)),
      .load_val (MON_DELAY_CYC),
      .tick     (1'b1),
      .done     (mon_done)
   );

   // ****************************************************************
   // state and control registers
   // ****************************************************************
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= ST_HOLD;
         first_reg     <= 1'b1;
         two_speed_reg <= 1'b0;
         target_reg    <= `RSQ_OSC_FRC;
         trap_reg      <= 1'b0;
         mon_reg       <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         first_reg <= 1'b0;
         if (start) begin
            target_reg    <= post_sel;
            two_speed_reg <= two_speed_enable &&
                             (post_sel == `RSQ_OSC_PRI || post_sel == `RSQ_OSC_PRIPLL);
            trap_reg      <= 1'b0;
            mon_reg       <= 1'b0;
         end else begin
            // primary takes over once its own delay completes
            if (two_speed_reg && xtal_done && (!need_pll || pll_locked)) begin
               two_speed_reg <= 1'b0;
            end
            // supervise from MON_DELAY_CYC cycles after reset release, even while a slow crystal still starts
            if (clock_fail_monitor_enable && (state_reg != ST_HOLD) && mon_done &&
                !mon_reg) begin
               mon_reg <= 1'b1;
               if (!clock_valid) begin
                  trap_reg   <= 1'b1;
                  target_reg <= `RSQ_OSC_FRC;
               end
            end
         end
      end
   end

   // ****************************************************************
   // software registers; reset values depend on cause
   // ****************************************************************
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_cause_register        <= `RSQ_CAUSE_POR_VAL;
         oscillator_control_register <= 16'h0000;
         flash_control_register      <= `RSQ_FLASH_RST_VAL;
         rdata_reg                   <= 16'h0000;
      end else if (clk_en) begin
         rdata_reg <= 16'h0000;
         if (reg_rd) begin
            case (reg_addr)
               `RSQ_ADDR_CAUSE:  rdata_reg <= reset_cause_register;
               `RSQ_ADDR_OSC:    rdata_reg <= oscillator_control_register;
               `RSQ_ADDR_FLASH:  rdata_reg <= flash_control_register;
               `RSQ_ADDR_STATUS: rdata_reg <= {11'h000, mon_reg, trap_reg, exec_enable,
                                               state_reg};
               default:          rdata_reg <= 16'h0000;
            endcase
         end
         if (reg_wr && reg_addr == `RSQ_ADDR_CAUSE) begin
            reset_cause_register <= reg_wdata & `RSQ_CAUSE_MASK;
         end
         if (reg_wr && reg_addr == `RSQ_ADDR_FLASH) begin
            flash_control_register <= reg_wdata;
         end
         if (reg_wr && reg_addr == `RSQ_ADDR_OSC) begin
            oscillator_control_register[`RSQ_OSC_CUR_HI:`RSQ_OSC_CUR_LO] <=
               reg_wdata[`RSQ_OSC_CUR_HI:`RSQ_OSC_CUR_LO];
         end
         // hardware set wins over a software write in the same cycle
         if (start) begin
            if (is_por) begin
               reset_cause_register   <= `RSQ_CAUSE_POR_VAL;
               flash_control_register <= `RSQ_FLASH_RST_VAL;
            end else begin
               reset_cause_register <= reset_cause_register | req_vec;
            end
            oscillator_control_register <= {1'b0, post_sel, 12'h000};
         end else begin
            oscillator_control_register[`RSQ_OSC_CUR_HI:`RSQ_OSC_CUR_LO] <=
               (two_speed_reg ? `RSQ_OSC_FRC : target_reg);
            oscillator_control_register[`RSQ_OSC_FAIL_BIT] <= trap_reg;
         end
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign master_system_reset = (state_reg == ST_HOLD);
   assign exec_enable         = (state_reg == ST_IDLE) || (state_reg == ST_MON);
   assign clock_source        = oscillator_control_register[`RSQ_OSC_CUR_HI:`RSQ_OSC_CUR_LO];
   assign osc_fail_trap       = trap_reg;
   assign monitor_active      = mon_reg;
   assign reg_rdata           = rdata_reg;
endmodule // rsq_reset_seq

// File: design/rsq_defs.vh
`ifndef RSQ_DEFS_VH
`define RSQ_DEFS_VH
// ****************************************************************
// register offsets (own map)
// ****************************************************************
`define RSQ_ADDR_CAUSE      4'h0
`define RSQ_ADDR_OSC        4'h1
`define RSQ_ADDR_FLASH      4'h2
`define RSQ_ADDR_STATUS     4'h3
// ****************************************************************
// reset cause flag positions
// ****************************************************************
`define RSQ_F_POR           0
`define RSQ_F_BOR           1
`define RSQ_F_WDT           4
`define RSQ_F_SWR           6
`define RSQ_F_PIN           7
`define RSQ_F_CM            9
`define RSQ_F_IOP           14
`define RSQ_F_TRAP          15
`define RSQ_CAUSE_MASK      16'hc2d3
`define RSQ_CAUSE_POR_VAL   16'h0003
// ****************************************************************
// oscillator codes and fields
// ****************************************************************
`define RSQ_OSC_FRC         3'h0
`define RSQ_OSC_FRCPLL      3'h1
`define RSQ_OSC_PRI         3'h2
`define RSQ_OSC_PRIPLL      3'h3
`define RSQ_OSC_SOSC        3'h4
`define RSQ_OSC_LOW_POWER_RC_OSCILLATOR        3'h5
`define RSQ_OSC_DCO         3'h6
`define RSQ_OSC_FRCDIV      3'h7
`define RSQ_OSC_CUR_HI      14
`define RSQ_OSC_CUR_LO      12
`define RSQ_OSC_FAIL_BIT    3
`define RSQ_FLASH_RST_VAL   16'h0000
// ****************************************************************
// timing (ns) and counts at 5 ns
// ****************************************************************
`define RSQ_CLK_NS          16'h0005
`define RSQ_POR_NS          16'h2710
`define RSQ_RST_NS          16'h07d0
`define RSQ_POR_CYC         (`RSQ_POR_NS / `RSQ_CLK_NS)
`define RSQ_RST_CYC         (`RSQ_RST_NS / `RSQ_CLK_NS)
`define RSQ_XTAL_PERIODS    11'h400
`endif

// File: design/rsq_delay_cnt.v
`timescale 1ns/100ps
// ****************************************************************
// down counter: load then count to zero, done while zero
// ****************************************************************
module rsq_delay_cnt (
   sys_clk,
   rst_n,
   clk_en,
   load,
   load_val,
   tick,
   done
);
   input         sys_clk;   // block clock
   input         rst_n;     // synchronised reset
   input         clk_en;    // freeze when low
   input         load;      // start new wait
   input  [15:0] load_val;  // cycles to wait
   input         tick;      // counting event
   output        done;      // wait finished

   wire          sys_clk;
   wire          rst_n;
   wire          clk_en;
   wire          load;
   wire   [15:0] load_val;
   wire          tick;
   reg    [15:0] cnt_reg;   // remaining count

   // ****************************************************************
   // counter
   // ****************************************************************
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 16'h0000;
      end else if (clk_en) begin
         if (load) begin
            cnt_reg <= load_val;
         end else if (tick && (cnt_reg != 16'h0000)) begin
            cnt_reg <= cnt_reg - 16'h0001;
         end
      end
   end

   assign done = (cnt_reg == 16'h0000);
endmodule // rsq_delay_cnt

// File: dv/rsq_reset_seq_assertions.sv
`timescale 1ns/100ps
// ****
// port checker for the reset sequencer
// ****
module rsq_reset_seq_chk #(
   parameter REG_WAKE_CYC = 16'd200  // regulator wake cycles
) (
   input wire logic       sys_clk,
   input wire logic       reset_n,
   input wire logic       clk_en,
   input wire logic       por_event,
   input wire logic       brownout_low,
   input wire logic [1:0] brownout_enable_config,
   input wire logic [2:0] initial_oscillator_select,
   input wire logic       clock_switch_enable,
   input wire logic       two_speed_enable,
   input wire logic       clock_fail_monitor_enable,
   input wire logic       clock_valid,
   input wire logic       master_system_reset,
   input wire logic       exec_enable,
   input wire logic [2:0] clock_source,
   input wire logic       osc_fail_trap,
   input wire logic       monitor_active
);
   logic [15:0] hold_reg;  // cycles of the current reset stretch
   logic        long_reg;  // power-on seen in this stretch
   logic        mid_reg;   // brown-out seen in this stretch
   logic [2:0]  src_reg;   // clock source while running
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // the first stretch after reset counts as a power-on
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_reg <= 16'h0000;
         long_reg <= 1'b1;
         mid_reg  <= 1'b0;
         src_reg  <= 3'h0;
      end else begin
         hold_reg <= master_system_reset ? hold_reg + {15'h0000, clk_en} : 16'h0000;
         long_reg <= por_event | (long_reg & master_system_reset);
         mid_reg  <= (brownout_low & |brownout_enable_config) | (mid_reg & master_system_reset);
         if (!master_system_reset) src_reg <= clock_source;
      end
   end
   sequence mon_wait;
      !monitor_active ##[1:12] monitor_active;
   endsequence
   a_por_hold: assert property ($fell(master_system_reset) && long_reg |->
      hold_reg >= 16'd2400 + REG_WAKE_CYC && hold_reg <= 16'd2410 + REG_WAKE_CYC)
      else $error("power-on hold length wrong");
   a_bor_hold: assert property ($fell(master_system_reset) && mid_reg && !long_reg
      && clock_source != 3'h6 |-> hold_reg >= 16'd400 + REG_WAKE_CYC
      && hold_reg <= 16'd404 + REG_WAKE_CYC) else $error("brown-out hold length wrong");
   a_short_hold: assert property ($fell(master_system_reset) && !mid_reg && !long_reg
      |-> hold_reg >= 16'd400 && hold_reg <= 16'd404) else $error("short hold length wrong");
   a_exec_gate: assert property (exec_enable |-> !master_system_reset
      && !$past(master_system_reset)) else $error("cpu runs during reset");
   a_cfg_select: assert property ($fell(master_system_reset) && !two_speed_enable
      && (!clock_switch_enable || long_reg || mid_reg)
      |-> clock_source == initial_oscillator_select) else $error("config select not used");
   a_cur_select: assert property ($fell(master_system_reset) && clock_switch_enable
      && !long_reg && !mid_reg && !two_speed_enable |-> clock_source == src_reg)
      else $error("current select not kept");
   a_mon_start: assert property ($fell(master_system_reset) && clock_fail_monitor_enable
      && clock_valid |-> mon_wait) else $error("monitor start wrong");
   a_fail_trap: assert property ($fell(master_system_reset) && clock_fail_monitor_enable
      && !clock_valid |-> ##[1:12] osc_fail_trap) else $error("failure trap missing");
   a_fail_frc: assert property ($rose(osc_fail_trap) |-> ##[0:1] clock_source == 3'h0)
      else $error("no fast rc after failure");
endmodule // rsq_reset_seq_chk
bind rsq_reset_seq rsq_reset_seq_chk #(.REG_WAKE_CYC(REG_WAKE_CYC)) u_chk (.*);

// File: dv/reset_sequencer_clock_select_test.sv
`timescale 1ns/100ps
`include "rsq_defs.vh"
// ****
// reset sequencer bench
// ****
module reset_sequencer_clock_select_test;
   logic        sys_clk, reset_n, clk_en, osc_tick, pll_locked, clock_valid, reg_wr, reg_rd;
   logic        clock_switch_enable, two_speed_enable, clock_fail_monitor_enable;
   logic [1:0]  brownout_enable_config;
   logic [2:0]  initial_oscillator_select;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata, d, flash_val;
   logic [7:0]  req;  // one bit per reset request
   wire         por_event, brownout_low, config_mismatch_reset, trap_conflict_reset;
   wire         illegal_opcode_reset, software_reset_instruction, watchdog_timeout_reset;
   wire         master_clear_pin, master_system_reset, exec_enable, osc_fail_trap, monitor_active;
   wire  [15:0] reg_rdata;
   wire  [2:0]  clock_source;
   int          bad_count, tests_run, hold, ticks;
   int          fpos [6] = '{`RSQ_F_PIN, `RSQ_F_WDT, `RSQ_F_SWR, `RSQ_F_IOP, `RSQ_F_TRAP, `RSQ_F_CM};
   assign {brownout_low, por_event, config_mismatch_reset, trap_conflict_reset,
      illegal_opcode_reset, software_reset_instruction, watchdog_timeout_reset,
      master_clear_pin} = req;
   // short counts keep the run brief
   rsq_reset_seq #(.REG_WAKE_CYC(16'd4), .PLL_LOCK_CYC(16'd4), .FRC_START_CYC(16'd4),
      .DCO_START_CYC(16'd4), .MON_DELAY_CYC(16'd4)) DUT (.*);
   always #2.5 sys_clk = ~sys_clk;
   // crystal ticks every other cycle, so 1024 ticks outlast a short hold
   always @(posedge sys_clk) osc_tick <= ~osc_tick;
   task chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task rd(input logic [3:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // cycles held in reset, and ticks seen from reset entry until the cpu may run
   task wait_run();
      hold = 0;
      ticks = 0;
      while (master_system_reset === 1'b1 && hold < 5000) begin
         @(posedge sys_clk);
         #1 hold++;
         ticks += osc_tick;
      end
      while (exec_enable !== 1'b1 && ticks < 3000) begin
         @(posedge sys_clk);
         #1 ticks += osc_tick;
      end
      #40;  // monitor starts a few cycles after release
   endtask
   task fire(input int idx);
      @(posedge sys_clk);
      req <= 8'h01 << idx;
      @(posedge sys_clk);
      req <= 8'h00;
      #1 wait_run();
   endtask
   task report_and_stop();
      $display("checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #400000;
      bad_count++;
      report_and_stop();
   end
   initial begin
      {sys_clk, reset_n, reg_wr, reg_rd, osc_tick, two_speed_enable, req} = '0;
      {clock_fail_monitor_enable, reg_addr, reg_wdata, brownout_enable_config} = '0;
      {clk_en, pll_locked, clock_valid, clock_switch_enable} = '1;
      initial_oscillator_select = `RSQ_OSC_PRI;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      #1 wait_run();
      chk(16'(hold inside {[2404:2412]}), 16'h0001);
      chk(16'(ticks < 1220), 16'h0001);
      rd(`RSQ_ADDR_CAUSE);
      chk(d, `RSQ_CAUSE_POR_VAL);
      rd(`RSQ_ADDR_OSC);
      chk(16'(d[14:12]), 16'(`RSQ_OSC_PRI));
      rd(`RSQ_ADDR_FLASH);
      chk(d, `RSQ_FLASH_RST_VAL);
      rd(4'hf);
      chk(d, 16'h0000);
      wr(`RSQ_ADDR_CAUSE, 16'hffff);
      rd(`RSQ_ADDR_CAUSE);
      chk(d, `RSQ_CAUSE_MASK);
      chk(16'(master_system_reset), 16'h0000);
      wr(`RSQ_ADDR_FLASH, 16'h00a5);
      rd(`RSQ_ADDR_FLASH);
      flash_val = d;
      for (int i = 0; i < 6; i++) begin
         wr(`RSQ_ADDR_CAUSE, 16'h0000);
         fire(i);
         chk(16'(hold inside {[400:405]}), 16'h0001);
         chk(16'(ticks inside {[1022:1028]}), 16'h0001);
         rd(`RSQ_ADDR_CAUSE);
         chk(d, 16'h0001 << fpos[i]);
         rd(`RSQ_ADDR_FLASH);
         chk(d, flash_val);
      end
      initial_oscillator_select <= `RSQ_OSC_LOW_POWER_RC_OSCILLATOR;
      fire(1);
      chk(16'(clock_source), 16'(`RSQ_OSC_PRI));
      clock_switch_enable <= 1'b0;
      fire(1);
      chk(16'(clock_source), 16'(`RSQ_OSC_LOW_POWER_RC_OSCILLATOR));
      {clock_switch_enable, brownout_enable_config} <= 3'b101;
      wr(`RSQ_ADDR_CAUSE, 16'h0000);
      fire(7);
      chk(16'(hold inside {[404:409]}), 16'h0001);
      rd(`RSQ_ADDR_CAUSE);
      chk(d, 16'h0002);
      brownout_enable_config <= 2'h0;
      fire(7);
      chk(16'(hold), 16'h0000);
      initial_oscillator_select <= `RSQ_OSC_DCO;
      brownout_enable_config <= 2'h3;
      fire(7);
      chk(16'(hold inside {[2404:2409]}), 16'h0001);
      fire(6);
      rd(`RSQ_ADDR_FLASH);
      chk(d, `RSQ_FLASH_RST_VAL);
      clock_fail_monitor_enable <= 1'b1;
      fire(2);
      chk(16'(monitor_active), 16'h0001);
      clock_valid <= 1'b0;
      fire(2);
      chk(16'(osc_fail_trap), 16'h0001);
      chk(16'(clock_source), 16'(`RSQ_OSC_FRC));
      {clock_fail_monitor_enable, clock_switch_enable, clock_valid, two_speed_enable} <= 4'h3;
      initial_oscillator_select <= `RSQ_OSC_PRI;
      fire(0);
      chk(16'(clock_source), 16'(`RSQ_OSC_FRC));
      while (clock_source !== `RSQ_OSC_PRI && ticks < 3000) @(posedge sys_clk) ticks++;
      chk(16'(clock_source), 16'(`RSQ_OSC_PRI));
      // pll source without lock stays blocked, frozen clock enable holds it
      {two_speed_enable, pll_locked} <= 2'b00;
      initial_oscillator_select <= `RSQ_OSC_FRCPLL;
      fire(0);
      chk(16'(exec_enable), 16'h0000);
      clk_en <= 1'b0;
      pll_locked <= 1'b1;
      #40 chk(16'(exec_enable), 16'h0000);
      clk_en <= 1'b1;
      #40 chk(16'(exec_enable), 16'h0001);
      report_and_stop();
   end
endmodule // reset_sequencer_clock_select_test
